/* hdl/i2c_target.sv */
// serial two-wire target: address match, register pointer, byte reads and writes
`timescale 1ns/100ps
`default_nettype none

module i2c_target (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_b_i,
    input  wire logic [6:0]          own_addr_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_n_o,
    input  wire logic [7:0]          rdata_i,
    output reg_lock_pkg::reg_req_t   req_o
);
    reg_lock_pkg::i2c_state_t st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       scl_r, sda_r, low_r, low_nxt, rw_r, rw_nxt, first_r, first_nxt;
    logic       ack_r, ack_nxt;
    reg_lock_pkg::reg_req_t req_nxt;
    logic       rise, fall, start, stop;

    // ----------------------------------------------------------------
    // bus events
    // ----------------------------------------------------------------
    assign rise  = scl_i & ~scl_r;
    assign fall  = ~scl_i & scl_r;
    assign start = scl_i & scl_r & sda_r & ~sda_i;
    assign stop  = scl_i & scl_r & ~sda_r & sda_i;
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~low_r;

    // next state; the target only ever pulls low, a one is a released line
    always_comb
    begin
        st_nxt = st_r; sh_nxt = sh_r; ptr_nxt = ptr_r; cnt_nxt = cnt_r;
        low_nxt = low_r; rw_nxt = rw_r; first_nxt = first_r; ack_nxt = ack_r;
        req_nxt = '0;
        // the address follows the pointer so reads see the register they aim at
        req_nxt.addr = ptr_nxt;
        req_nxt.wdata = req_o.wdata;
        if (start)
        begin
            st_nxt = reg_lock_pkg::ST_ADDR; cnt_nxt = 4'h0; low_nxt = 1'b0;
            first_nxt = 1'b1;
        end
        else if (stop)
        begin
            st_nxt = reg_lock_pkg::ST_IDLE; low_nxt = 1'b0;
        end
        else if (rise)
        begin
            if (st_r == reg_lock_pkg::ST_ADDR || st_r == reg_lock_pkg::ST_WR)
            begin
                sh_nxt = {sh_r[6:0], sda_i}; cnt_nxt = cnt_r + 4'h1;
            end
            if (st_r == reg_lock_pkg::ST_RD_ACK)
                ack_nxt = ~sda_i;
        end
        else if (fall)
        begin
            unique case (st_r)
                reg_lock_pkg::ST_IDLE: ;
                reg_lock_pkg::ST_ADDR:
                    if (cnt_r == 4'h8)
                    begin
                        rw_nxt = sh_r[0];
                        low_nxt = (sh_r[7:1] == own_addr_i);
                        st_nxt = low_nxt ? reg_lock_pkg::ST_ADDR_ACK : reg_lock_pkg::ST_IDLE;
                    end
                reg_lock_pkg::ST_ADDR_ACK, reg_lock_pkg::ST_RD_ACK:
                    if (rw_r && (st_r == reg_lock_pkg::ST_ADDR_ACK || ack_r))
                    begin
                        sh_nxt = rdata_i; ptr_nxt = ptr_r + 8'h01;
                        low_nxt = ~rdata_i[7]; cnt_nxt = 4'h1;
                        st_nxt = reg_lock_pkg::ST_RD;
                    end
                    else
                    begin
                        low_nxt = 1'b0; cnt_nxt = 4'h0;
                        st_nxt = rw_r ? reg_lock_pkg::ST_IDLE : reg_lock_pkg::ST_WR;
                    end
                reg_lock_pkg::ST_WR:
                    if (cnt_r == 4'h8)
                    begin
                        // every byte is acknowledged, locked or not
                        low_nxt = 1'b1; st_nxt = reg_lock_pkg::ST_WR_ACK;
                        first_nxt = 1'b0;
                        if (first_r)
                            ptr_nxt = sh_r;
                        else
                        begin
                            req_nxt.wr = 1'b1; req_nxt.addr = ptr_r;
                            req_nxt.wdata = sh_r; ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                reg_lock_pkg::ST_WR_ACK:
                begin
                    low_nxt = 1'b0; cnt_nxt = 4'h0; st_nxt = reg_lock_pkg::ST_WR;
                end
                reg_lock_pkg::ST_RD:
                    if (cnt_r == 4'h8)
                    begin
                        low_nxt = 1'b0; st_nxt = reg_lock_pkg::ST_RD_ACK;
                    end
                    else
                    begin
                        low_nxt = ~sh_r[3'(4'h7 - cnt_r)]; cnt_nxt = cnt_r + 4'h1;
                    end
            endcase
        end
    end

    // registers of the front end
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= reg_lock_pkg::ST_IDLE; sh_r <= 8'h00; ptr_r <= 8'h00;
            cnt_r <= 4'h0; low_r <= 1'b0; rw_r <= 1'b0; first_r <= 1'b0;
            ack_r <= 1'b0; req_o <= '0; scl_r <= 1'b1; sda_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt; sh_r <= sh_nxt; ptr_r <= ptr_nxt; cnt_r <= cnt_nxt;
            low_r <= low_nxt; rw_r <= rw_nxt; first_r <= first_nxt;
            ack_r <= ack_nxt; req_o <= req_nxt; scl_r <= scl_i; sda_r <= sda_i;
        end
    end

endmodule : i2c_target

`default_nettype wire

/* hdl/reg_lock_defs.svh */
// offsets, field positions, reset values and group address ranges of the lock bank
`ifndef REG_LOCK_DEFS_SVH
`define REG_LOCK_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_WD_KEY      8'h83
`define OFS_LOCK_FIRST  8'hf0
`define OFS_LOCK_SECOND 8'hf1
`define OFS_TARGET_ADDR 8'hf9
`define OFS_FAULT       8'h90

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define RST_WD_KEY      8'h00
`define RST_LOCK        7'h00
`define RST_FAULT       1'b0
`define LOCK_BITS       7
`define FAULT_RST_LINE  0
`define SEQ_BIST_A      3'h5
`define SEQ_BIST_B      3'h6

// ----------------------------------------------------------------
// group address ranges, index equals lock bit position
// ----------------------------------------------------------------
`define GRP_LO {8'h60, 8'h40, 8'h20, 8'h10, 8'h80, 8'h70, 8'h00}
`define GRP_HI {8'h6f, 8'h5f, 8'h3f, 8'h1f, 8'h82, 8'h7f, 8'h0f}

`endif

/* hdl/reg_lock_pkg.sv */
// types shared by the lock bank and its serial target front end
package reg_lock_pkg;

    // one register access from the serial front end
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // serial target states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } i2c_state_t;

endpackage : reg_lock_pkg

/* hdl/register_group_write_lock.sv */
// register group write lock bank with watchdog key, target address and fault flag
// What this block does
// - watchdog key register, read-write, reset zero
// - group locked only when both bits set
// - lock registers at f0, f1, reset zero
// - host cannot clear a set lock bit
// - self-test on sequence 5/6 exit clears locks
// - bit 6 drops working register writes
// - bit 5 drops sleep sequence writes
// - bit 4 drops power sequence writes
// - bit 3 drops slot configuration writes
// - bit 2 drops watchdog configuration writes
// - bit 1 drops clock register writes
// - bit 0 drops control writes; bit 7 reserved
// - read-only target address from nonvolatile store
// - external low on reset line raises fault, interrupt
// - writing one clears only that fault flag
// - fault flags stay until cleared by host
`timescale 1ns/100ps
`default_nettype none
`include "reg_lock_defs.svh"

module register_group_write_lock #(
    parameter int LOCK_BITS = `LOCK_BITS
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_n_o,
    input  wire logic [6:0]           stored_target_address_i,
    input  wire logic                 bist_run_i,
    input  wire logic [2:0]           bist_exit_seq_i,
    input  wire logic                 test_at_shutdown_i,
    input  wire logic                 reset_output_line_i,
    input  wire logic                 reset_drive_i,
    output logic                      interrupt_output_line_o,
    output logic                      interrupt_output_line_oe_n_o,
    output logic                      watchdog_kick_o,
    output logic [LOCK_BITS-1:0]      lock_effective_o,
    output reg_lock_pkg::reg_req_t    ext_req_o,
    input  wire logic [7:0]           ext_rdata_i
);
    localparam logic [LOCK_BITS-1:0][7:0] GRP_LO = `GRP_LO;
    localparam logic [LOCK_BITS-1:0][7:0] GRP_HI = `GRP_HI;

    reg_lock_pkg::reg_req_t req;
    logic [7:0]           rdata, key_r, key_nxt;
    logic [LOCK_BITS-1:0] first_r, first_nxt, second_r, second_nxt, hit;
    logic [6:0]           addr_r;
    logic                 fault_r, fault_nxt, kick_nxt, bist_clr, fault_evt;
    reg_lock_pkg::reg_req_t ext_nxt;

    // ----------------------------------------------------------------
    // serial front end
    // ----------------------------------------------------------------
    i2c_target u_i2c (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .own_addr_i (addr_r),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_n_o (sda_oe_n_o),
        .rdata_i    (rdata),
        .req_o      (req)
    );

    // ----------------------------------------------------------------
    // group decode and effective lock
    // ----------------------------------------------------------------
    // a single register cannot lock a group, guarding against one stray write
    assign lock_effective_o = first_r & second_r;

    // one address window per lock bit
    for (genvar g = 0; g < LOCK_BITS; g++)
    begin : g_grp
        assign hit[g] = (req.addr >= GRP_LO[g]) && (req.addr <= GRP_HI[g]);
    end

    // self-test on leaving shutdown sequence 5 or 6 clears the locks
    assign bist_clr = bist_run_i && test_at_shutdown_i &&
                      (bist_exit_seq_i == `SEQ_BIST_A || bist_exit_seq_i == `SEQ_BIST_B);

    // a low on the line that we are not pulling is an outside reset
    assign fault_evt = ~reset_output_line_i & ~reset_drive_i;

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    always_comb
    begin
        key_nxt = key_r; first_nxt = first_r; second_nxt = second_r;
        fault_nxt = fault_r; kick_nxt = 1'b0;
        ext_nxt = '0;
        ext_nxt.addr = ext_req_o.addr;
        ext_nxt.wdata = ext_req_o.wdata;
        if (req.wr)
        begin
            if (req.addr == `OFS_WD_KEY)
            begin
                key_nxt = req.wdata; kick_nxt = 1'b1;
            end
            // set-only: ones are or-ed in, zeros leave bits alone
            if (req.addr == `OFS_LOCK_FIRST)
                first_nxt = first_r | req.wdata[LOCK_BITS-1:0];
            if (req.addr == `OFS_LOCK_SECOND)
                second_nxt = second_r | req.wdata[LOCK_BITS-1:0];
            if (req.addr == `OFS_FAULT && req.wdata[`FAULT_RST_LINE])
                fault_nxt = 1'b0;
            // locked group writes vanish here, the front end still acked them
            if ((hit & ~lock_effective_o) != '0)
            begin
                ext_nxt = req;
            end
        end
        // the clear behaves like a power-on for the locks, so it beats a set
        if (bist_clr)
        begin
            first_nxt = `RST_LOCK; second_nxt = `RST_LOCK;
        end
        // a fault in the clear cycle is kept
        if (fault_evt)
            fault_nxt = 1'b1;
    end

    // registers, reset only by the power-on reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            key_r <= `RST_WD_KEY; first_r <= `RST_LOCK; second_r <= `RST_LOCK;
            fault_r <= `RST_FAULT; watchdog_kick_o <= 1'b0; ext_req_o <= '0;
            addr_r <= 7'h00;
        end
        else
        begin
            key_r <= key_nxt; first_r <= first_nxt; second_r <= second_nxt;
            fault_r <= fault_nxt; watchdog_kick_o <= kick_nxt; ext_req_o <= ext_nxt;
            addr_r <= stored_target_address_i;
        end
    end

    // ----------------------------------------------------------------
    // read mux and interrupt line
    // ----------------------------------------------------------------
    // reserved bit 7 of the lock and address registers reads zero
    always_comb
    begin
        rdata = 8'h00;
        if (req.addr == `OFS_WD_KEY)
            rdata = key_r;
        else if (req.addr == `OFS_LOCK_FIRST)
            rdata = {1'b0, first_r};
        else if (req.addr == `OFS_LOCK_SECOND)
            rdata = {1'b0, second_r};
        else if (req.addr == `OFS_TARGET_ADDR)
            rdata = {1'b0, addr_r};
        else if (req.addr == `OFS_FAULT)
            rdata = {7'h00, fault_r};
        else if (hit != '0)
            rdata = ext_rdata_i;
    end

    // open-drain interrupt pulled low while a fault is held
    assign interrupt_output_line_o = 1'b0;
    assign interrupt_output_line_oe_n_o = ~fault_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    AST_KEY_WRITE: assert property (
        req.wr && req.addr == `OFS_WD_KEY |=> key_r == $past(req.wdata) && watchdog_kick_o)
        else $error("key write not stored");
    AST_BOTH_NEEDED: assert property (
        req.wr && hit[0] && !(first_r[0] && second_r[0]) |=> ext_req_o.wr)
        else $error("group locked by one register");
    AST_LOCK_RESET: assert property (
        $rose(rst_b_i) |-> first_r == '0 && second_r == '0)
        else $error("lock not zero after reset");
    AST_LOCK_STICKY: assert property (
        !bist_clr |=> (first_r & $past(first_r)) == $past(first_r)
                      && (second_r & $past(second_r)) == $past(second_r))
        else $error("lock bit cleared by host");
    AST_BIST_CLEAR: assert property (
        bist_clr |=> first_r == '0 && second_r == '0)
        else $error("self-test did not clear locks");
    AST_LOCKED_DROP: assert property (
        req.wr && (hit & lock_effective_o) != '0 |=> !ext_req_o.wr)
        else $error("locked write passed");
    AST_OPEN_PASS: assert property (
        req.wr && hit != '0 && (hit & lock_effective_o) == '0
        |=> ext_req_o.wr && ext_req_o.addr == $past(req.addr))
        else $error("open write lost");
    AST_ADDR_RO: assert property (
        req.wr && req.addr == `OFS_TARGET_ADDR
        |=> addr_r == $past(stored_target_address_i))
        else $error("target address changed by write");
    AST_FAULT_SET: assert property (
        fault_evt |=> fault_r && !interrupt_output_line_oe_n_o)
        else $error("fault not raised");
    AST_FAULT_W1C: assert property (
        req.wr && req.addr == `OFS_FAULT && req.wdata[0] && !fault_evt |=> !fault_r)
        else $error("fault not cleared");
    AST_FAULT_HOLD: assert property (
        fault_r && !(req.wr && req.addr == `OFS_FAULT && req.wdata[0]) |=> fault_r [*1])
        else $error("fault dropped by itself");
    AST_SET_ONLY: assert property (
        req.wr && req.addr == `OFS_LOCK_FIRST && !bist_clr
        |=> first_r == ($past(first_r) | $past(req.wdata[LOCK_BITS-1:0])))
        else $error("lock bit not set");

    COV_LOCK_BOTH: cover property (lock_effective_o[6] ##1 req.wr && hit[6]);
    COV_BIST: cover property (lock_effective_o != '0 ##1 bist_clr);
    COV_FAULT_CLR: cover property (fault_r ##[1:50] !fault_r);

endmodule : register_group_write_lock

`default_nettype wire

/* tb/i2c_host_model.sv */
// host model for the two-wire register bus: start, stop and byte transfers
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    // both lines idle released; the pull-up keeps them high
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // six clocks per half period keeps clear of the target's four-clock minimum
    task automatic half_wait();
        repeat (6) @(posedge clk_sys_i);
    endtask : half_wait

    // also serves as repeated start, entered with scl low
    task automatic start();
        sda_o <= 1'b1;
        half_wait();
        scl_o <= 1'b1;
        half_wait();
        sda_o <= 1'b0;
        half_wait();
        scl_o <= 1'b0;
    endtask : start

    task automatic stop();
        half_wait();
        sda_o <= 1'b0;
        half_wait();
        scl_o <= 1'b1;
        half_wait();
        sda_o <= 1'b1;
        half_wait();
    endtask : stop

    // data changes only while scl is low; the wire is sampled at the end of the high phase, just before scl falls
    task automatic clock_bit(input logic b, output logic got);
        half_wait();
        sda_o <= b;
        half_wait();
        scl_o <= 1'b1;
        half_wait();
        got = sda_i;
        scl_o <= 1'b0;
    endtask : clock_bit

    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--)
            clock_bit(tx[i], rx[i]);
        clock_bit(ack_in, ack_out);
    endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the register group write lock bank
`timescale 1ns/100ps
`default_nettype none
`include "reg_lock_defs.svh"

module tb_top;
    localparam logic [6:0]      own_addr  = 7'h2a;
    localparam logic [6:0][7:0] grp_first = `GRP_LO;
    // rows: offset, written value, value read back
    localparam logic [5:0][23:0] rows = {24'h83a5a5, 24'h835a5a, 24'hf9ff2a,
                                         24'hc07700, 24'h900100, 24'h05113c};
    // rows: {exit sequence, test option}, lock state expected after the pulse
    localparam logic [3:0][11:0] bist_rows = {12'h940, 12'hc40, 12'hd00, 12'hb00};
    logic       clk_sys_i, rst_b_i, scl, sda_host, sda_d, sda_oe_n, bist_run;
    logic       test_at_shutdown, rst_line, rst_drive, irq_d, irq_oe_n, kick, ack_v;
    logic [2:0] bist_seq;
    logic [6:0] lock_eff;
    logic [7:0] rd_v, last_d;
    int         n_mismatch, n_tests, n_fwd, n_kick, n0;
    reg_lock_pkg::reg_req_t ext_req;
    wire logic  sda_wire;

    // open-drain wire: either party may pull it low
    assign sda_wire = sda_host & (sda_oe_n | sda_d);

    register_group_write_lock register_group_write_lock_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .stored_target_address_i(own_addr),
        .bist_run_i(bist_run), .bist_exit_seq_i(bist_seq),
        .test_at_shutdown_i(test_at_shutdown), .reset_output_line_i(rst_line),
        .reset_drive_i(rst_drive), .interrupt_output_line_o(irq_d),
        .interrupt_output_line_oe_n_o(irq_oe_n), .watchdog_kick_o(kick),
        .lock_effective_o(lock_eff), .ext_req_o(ext_req), .ext_rdata_i(8'h3c));

    i2c_host_model i2c_host_model_i (
        .clk_sys_i(clk_sys_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(sda_host));

    // ----------------------------------------------------------------
    // clock, monitors, checks
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // one-cycle pulses are counted in the cycle they stand
    always @(posedge clk_sys_i)
    begin
        if (ext_req.wr === 1'b1) n_fwd++;
        if (ext_req.wr === 1'b1) last_d = ext_req.wdata;
        if (kick === 1'b1) n_kick++;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ack of the data byte is kept so a dropped write can still be checked for it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        logic       k;
        i2c_host_model_i.start();
        i2c_host_model_i.xfer({own_addr, 1'b0}, 1'b1, x, k);
        i2c_host_model_i.xfer(a, 1'b1, x, k);
        i2c_host_model_i.xfer(d, 1'b1, x, ack_v);
        i2c_host_model_i.stop();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [7:0] x;
        logic       k;
        i2c_host_model_i.start();
        i2c_host_model_i.xfer({own_addr, 1'b0}, 1'b1, x, k);
        i2c_host_model_i.xfer(a, 1'b1, x, k);
        i2c_host_model_i.start();
        i2c_host_model_i.xfer({own_addr, 1'b1}, 1'b1, x, k);
        i2c_host_model_i.xfer(8'hff, 1'b1, rd_v, k);
        i2c_host_model_i.stop();
    endtask : rd

    task automatic do_reset();
        rst_b_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask : do_reset

    // watchdog sized well above the roughly 40k cycles the sequence needs
    initial
    begin
        repeat (90000) @(posedge clk_sys_i);
        n_mismatch++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_b_i, bist_run, bist_seq, test_at_shutdown, rst_drive} = '0;
        rst_line = 1'b1;
        do_reset();
        rd(8'hf0);
        check(rd_v, 8'h00);
        rd(8'hf1);
        check(rd_v, 8'h00);
        rd(8'h83);
        check(rd_v, 8'h00);
        for (int r = 5; r >= 0; r--)
        begin
            wr(rows[r][23:16], rows[r][15:8]);
            rd(rows[r][23:16]);
            check(rd_v, rows[r][7:0]);
        end
        check(8'(n_kick), 8'h02);
        // one group at a time: a bit in one register alone must not lock
        for (int b = 0; b < 7; b++)
        begin
            n0 = n_fwd;
            wr(grp_first[b], 8'h11);
            wr(8'hf0, 8'h01 << b);
            wr(grp_first[b], 8'h22);
            check(last_d, 8'h22);
            wr(8'hf1, 8'h01 << b);
            wr(grp_first[b], 8'h33);
            check({1'b0, lock_eff}, 8'h7f >> (6 - b));
            check(8'(n_fwd - n0), 8'h02);
            check({7'h00, ack_v}, 8'h00);
        end
        wr(8'hf0, 8'h80);
        rd(8'hf0);
        check(rd_v, 8'h7f);
        // only an exit from sequence 5 or 6 with the option on clears locks
        for (int r = 3; r >= 0; r--)
        begin
            wr(8'hf0, 8'h40);
            wr(8'hf1, 8'h40);
            bist_seq <= bist_rows[r][11:9];
            test_at_shutdown <= bist_rows[r][8];
            bist_run <= 1'b1;
            @(posedge clk_sys_i);
            bist_run <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            check({1'b0, lock_eff} & 8'h40, bist_rows[r][7:0]);
        end
        rd(8'hf1);
        check(rd_v, 8'h00);
        // outside low on the reset line is a fault; own drive is not
        rst_drive <= 1'b1;
        rst_line <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_line <= 1'b1;
        rst_drive <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check({7'h00, irq_oe_n}, 8'h01);
        rst_line <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_line <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check({7'h00, irq_oe_n}, 8'h00);
        rd(8'h90);
        check(rd_v, 8'h01);
        wr(8'h90, 8'h00);
        check({7'h00, irq_oe_n}, 8'h00);
        wr(8'h90, 8'h01);
        check({7'h00, irq_oe_n}, 8'h01);
        // a fresh power-on clears set lock bits
        wr(8'hf0, 8'h01);
        wr(8'hf1, 8'h01);
        check({1'b0, lock_eff}, 8'h01);
        do_reset();
        check({1'b0, lock_eff}, 8'h00);
        rd(8'hf0);
        check(rd_v, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
